// ===== bch_pkg.sv
// Package with register map, field positions and fixed values of the bridge header block
package bch_pkg;
  // Byte addresses of the implemented dwords
  localparam logic [7:0] ADDR_CMD_STATUS = 8'h04;
  localparam logic [7:0] ADDR_REV_CLASS  = 8'h08;
  localparam logic [7:0] ADDR_CACHE_HDR  = 8'h0C;
  localparam logic [7:0] ADDR_BUS_NUM    = 8'h18;
  // Status bit positions within the dword
  localparam int BIT_INT_STATUS   = 19;
  localparam int BIT_CAP_LIST     = 20;
  localparam int BIT_PARITY_MSTR  = 24;
  localparam int BIT_SIG_ABORT    = 27;
  localparam int BIT_RCV_ABORT    = 28;
  localparam int BIT_RCV_UNSUPP   = 29;
  localparam int BIT_SIG_SYSERR   = 30;
  localparam int BIT_POISON_DET   = 31;
  localparam int BIT_CLK66_CAP    = 21;
  localparam int BIT_FAST_B2B     = 23;
  localparam int BIT_SEL_TIME_LO  = 25;
  localparam int BIT_SEL_TIME_HI  = 26;
  // Fixed field values
  localparam logic [7:0] CLASS_PROG_IF   = 8'h00;
  localparam logic [7:0] CLASS_SUB       = 8'h04;
  localparam logic [7:0] CLASS_BASE      = 8'h06;
  localparam logic [7:0] LAT_TIMER_VALUE = 8'h00;
  localparam logic [7:0] HEADER_LAYOUT   = 8'h01;
  localparam logic [7:0] BYTE_RESET      = 8'h00;
  localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;
endpackage : bch_pkg

// ===== bch_header_regs.sv
// Bridge configuration header registers behind an APB slave
`timescale 1ns/1ps
`default_nettype none

module bch_header_regs #(
  parameter logic [7:0] SILICON_REV = 8'hA5  // Arbitrary value
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  input  wire logic        clkEn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        parityErrorResponseEnable,
  input  wire logic        systemErrorReportEnable,
  input  wire logic        parityErrorEvent,
  input  wire logic        completerAbortSent,
  input  wire logic        completerAbortReceived,
  input  wire logic        unsupportedReqReceived,
  input  wire logic        errorMessageSent,
  input  wire logic        poisonedPacketReceived,
  output logic [7:0]       upstreamBusNumber,
  output logic [7:0]       downstreamBusNumber
);

  // Sticky status flags, one per event source
  logic        parityFlag;
  logic        sigAbortFlag;
  logic        rcvAbortFlag;
  logic        rcvUnsuppFlag;
  logic        sysErrFlag;
  logic        poisonFlag;

  // Writable byte behind the cache line field
  logic [7:0]  cacheLineSize;

  // Bus phase decode
  wire         setupPhase;
  wire         accessPhase;
  wire         doAccess;
  wire         doWrite;

  // Address hits, one per implemented dword
  wire         hitStatus;
  wire         hitRev;
  wire         hitCache;
  wire         hitBus;
  wire         hitAny;

  // Byte-lane write strobes
  wire         wrStatHi;
  wire         wrCache;
  wire         wrBus0;
  wire         wrBus1;

  // Write data split into the lanes that land in registers
  wire [7:0]   wdataLane0;
  wire [7:0]   wdataLane1;

  // Write-one-to-clear strobes
  wire         clrParity;
  wire         clrSysErr;
  wire         clrPoison;

  // Set conditions after the command enables
  wire         setParity;
  wire         setSigAbort;
  wire         setRcvAbort;
  wire         setRcvUnsupp;
  wire         setSysErr;
  wire         setPoison;

  // Next values of the flags
  wire         next_parityFlag;
  wire         next_sigAbortFlag;
  wire         next_rcvAbortFlag;
  wire         next_rcvUnsuppFlag;
  wire         next_sysErrFlag;
  wire         next_poisonFlag;

  // Next values of the writable bytes
  wire [7:0]   next_cacheLineSize;
  wire [7:0]   next_upstreamBusNumber;
  wire [7:0]   next_downstreamBusNumber;

  // Hardwired status fields
  wire         intPendingBit;
  wire         capListBit;
  wire         clk66CapBit;
  wire         fastB2bCapBit;
  wire [1:0]   selTimingBits;

  // Fixed fields of the identity and header dwords
  wire [23:0]  classCode;
  wire [7:0]   latTimerByte;
  wire [7:0]   headerByte;

  // Read words and the registered answer
  wire [31:0]  statusWord;
  wire [31:0]  revWord;
  wire [31:0]  cacheWord;
  wire [31:0]  busWord;
  wire [31:0]  readWord;
  wire [31:0]  next_prdata;
  wire         next_pready;
  wire         next_pslverr;

  // Setup latches the answer, access completes it; no wait states
  assign setupPhase  = psel & ~penable;
  assign accessPhase = psel & penable;
  assign doAccess    = accessPhase & pready & clkEn;
  assign doWrite     = doAccess & pwrite;

  // Address decode on the full byte address
  assign hitStatus = (paddr == bch_pkg::ADDR_CMD_STATUS);
  assign hitRev    = (paddr == bch_pkg::ADDR_REV_CLASS);
  assign hitCache  = (paddr == bch_pkg::ADDR_CACHE_HDR);
  assign hitBus    = (paddr == bch_pkg::ADDR_BUS_NUM);
  assign hitAny    = hitStatus | hitRev | hitCache | hitBus;

  // Only the selected byte lanes of a mapped dword are written
  // Status flags all sit in byte 3, so the other lanes of it write nothing
  assign wrStatHi = doWrite & hitStatus & pstrb[3];
  assign wrCache  = doWrite & hitCache & pstrb[0];
  assign wrBus0   = doWrite & hitBus & pstrb[0];
  assign wrBus1   = doWrite & hitBus & pstrb[1];

  // Lane data for the byte registers
  assign wdataLane0 = pwdata[7:0];
  assign wdataLane1 = pwdata[15:8];

  // A one written to the parity, system error or poison bit clears it; a zero leaves it
  assign clrParity = wrStatHi & pwdata[bch_pkg::BIT_PARITY_MSTR];
  assign clrSysErr = wrStatHi & pwdata[bch_pkg::BIT_SIG_SYSERR];
  assign clrPoison = wrStatHi & pwdata[bch_pkg::BIT_POISON_DET];

  // Parity and system error flags obey the command enables
  assign setParity    = parityErrorEvent & parityErrorResponseEnable;
  assign setSigAbort  = completerAbortSent;
  assign setRcvAbort  = completerAbortReceived;
  assign setRcvUnsupp = unsupportedReqReceived;
  assign setSysErr    = errorMessageSent & systemErrorReportEnable;
  assign setPoison    = poisonedPacketReceived;

  // Set beats clear, so an event in the clearing cycle is kept
  // Read-only flags only ever set; reset alone clears them
  assign next_parityFlag    = setParity | (parityFlag & ~clrParity);
  assign next_sigAbortFlag  = setSigAbort | sigAbortFlag;
  assign next_rcvAbortFlag  = setRcvAbort | rcvAbortFlag;
  assign next_rcvUnsuppFlag = setRcvUnsupp | rcvUnsuppFlag;
  assign next_sysErrFlag    = setSysErr | (sysErrFlag & ~clrSysErr);
  assign next_poisonFlag    = setPoison | (poisonFlag & ~clrPoison);

  // Writable bytes follow their strobes
  assign next_cacheLineSize       = wrCache ? wdataLane0 : cacheLineSize;
  assign next_upstreamBusNumber   = wrBus0 ? wdataLane0 : upstreamBusNumber;
  assign next_downstreamBusNumber = wrBus1 ? wdataLane1 : downstreamBusNumber;

  // Interrupt pending is never set, forwarded interrupts included
  // Legacy fields of a parallel bus read zero and take no writes
  assign intPendingBit = 1'b0;
  assign capListBit    = 1'b1;
  assign clk66CapBit   = 1'b0;
  assign fastB2bCapBit = 1'b0;
  assign selTimingBits = 2'h0;

  // Class code, latency timer and header layout are hardwired
  assign classCode    = {bch_pkg::CLASS_BASE, bch_pkg::CLASS_SUB, bch_pkg::CLASS_PROG_IF};
  assign latTimerByte = bch_pkg::LAT_TIMER_VALUE;
  assign headerByte   = bch_pkg::HEADER_LAYOUT;

  // Status dword bit by bit; command half lives outside this block
  assign statusWord[bch_pkg::BIT_POISON_DET]  = poisonFlag;
  assign statusWord[bch_pkg::BIT_SIG_SYSERR]  = sysErrFlag;
  assign statusWord[bch_pkg::BIT_RCV_UNSUPP]  = rcvUnsuppFlag;
  assign statusWord[bch_pkg::BIT_RCV_ABORT]   = rcvAbortFlag;
  assign statusWord[bch_pkg::BIT_SIG_ABORT]   = sigAbortFlag;
  assign statusWord[bch_pkg::BIT_SEL_TIME_HI:bch_pkg::BIT_SEL_TIME_LO] = selTimingBits;
  assign statusWord[bch_pkg::BIT_PARITY_MSTR] = parityFlag;
  assign statusWord[bch_pkg::BIT_FAST_B2B]    = fastB2bCapBit;
  assign statusWord[22]                       = 1'b0;
  assign statusWord[bch_pkg::BIT_CLK66_CAP]   = clk66CapBit;
  assign statusWord[bch_pkg::BIT_CAP_LIST]    = capListBit;
  assign statusWord[bch_pkg::BIT_INT_STATUS]  = intPendingBit;
  assign statusWord[18:16]                    = 3'h0;
  assign statusWord[15:0]                     = 16'h0000;

  // Identity, header and bus number dwords
  assign revWord   = {classCode, SILICON_REV};
  assign cacheWord = {8'h00, headerByte, latTimerByte, cacheLineSize};
  assign busWord   = {16'h0000, downstreamBusNumber, upstreamBusNumber};

  // Read mux by address; unmapped reads return zero
  assign readWord = hitStatus ? statusWord :
                    hitRev    ? revWord :
                    hitCache  ? cacheWord :
                    hitBus    ? busWord : bch_pkg::WORD_ZERO;

  // Answer loads at the setup edge and stands for the access cycle
  // A write answers with zero data; an unmapped address with an error
  assign next_pready  = setupPhase;
  assign next_pslverr = setupPhase & ~hitAny;
  assign next_prdata  = (setupPhase & ~pwrite) ? readWord :
                        setupPhase ? bch_pkg::WORD_ZERO : prdata;

  // Registers below all share the asynchronous reset and the clock enable
  // With clkEn low nothing moves, not even the bus handshake, so an event
  // arriving then is not recorded; the source must hold it until enabled
  // Each register has its own short process fed by a next value above

  // Ready is high only in the access cycle after a setup
  // The answer never needs more time, so no wait states are inserted
  // Back-to-back transfers work since setup and access alternate
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
    end else if (clkEn) begin
      pready <= next_pready;
    end
  end

  // Error answer for addresses outside the implemented dwords
  // Raised together with ready, so the master sees both at one edge
  // Writes to such addresses change nothing
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pslverr <= 1'b0;
    end else if (clkEn) begin
      pslverr <= next_pslverr;
    end
  end

  // Read data taken at the setup edge
  // A flag set during the access cycle shows in the next read
  // Held between transfers so the bus does not toggle needlessly
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      prdata <= bch_pkg::WORD_ZERO;
    end else if (clkEn) begin
      prdata <= next_prdata;
    end
  end

  // Parity flag of the primary side
  // Set only while parity response is enabled
  // Cleared by a one in its bit, unless an error arrives in that cycle
  // Level events keep setting it for as long as they stand
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      parityFlag <= 1'b0;
    end else if (clkEn) begin
      parityFlag <= next_parityFlag;
    end
  end

  // Completer abort signalled by this port
  // Read-only, so software cannot clear it
  // Only reset brings it back to zero
  // Repeated events leave it set
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sigAbortFlag <= 1'b0;
    end else if (clkEn) begin
      sigAbortFlag <= next_sigAbortFlag;
    end
  end

  // Completer abort received in a completion
  // Read-only, so software cannot clear it
  // Only reset brings it back to zero
  // Repeated events leave it set
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rcvAbortFlag <= 1'b0;
    end else if (clkEn) begin
      rcvAbortFlag <= next_rcvAbortFlag;
    end
  end

  // Unsupported request received in a completion
  // Read-only, so software cannot clear it
  // Only reset brings it back to zero
  // Repeated events leave it set
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rcvUnsuppFlag <= 1'b0;
    end else if (clkEn) begin
      rcvUnsuppFlag <= next_rcvUnsuppFlag;
    end
  end

  // Error message sent upstream
  // Set only while system error reporting is enabled
  // Cleared by a one in its bit, unless a message goes out in that cycle
  // Disabling reporting later does not clear it
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sysErrFlag <= 1'b0;
    end else if (clkEn) begin
      sysErrFlag <= next_sysErrFlag;
    end
  end

  // Poisoned packet seen on the primary side
  // Set whatever the enables say
  // Cleared by a one in its bit, unless a packet arrives in that cycle
  // Level events keep setting it for as long as they stand
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      poisonFlag <= 1'b0;
    end else if (clkEn) begin
      poisonFlag <= next_poisonFlag;
    end
  end

  // Cache line size, kept only to be read back
  // Nothing else in the port looks at it
  // Written through byte lane 0 alone
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cacheLineSize <= bch_pkg::BYTE_RESET;
    end else if (clkEn) begin
      cacheLineSize <= next_cacheLineSize;
    end
  end

  // Number of the bus on the upstream side
  // Driven out for the routing logic of the port
  // Written through byte lane 0 alone
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      upstreamBusNumber <= bch_pkg::BYTE_RESET;
    end else if (clkEn) begin
      upstreamBusNumber <= next_upstreamBusNumber;
    end
  end

  // Number of the bus directly below the bridge
  // Driven out for the routing logic of the port
  // Written through byte lane 1 alone
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      downstreamBusNumber <= bch_pkg::BYTE_RESET;
    end else if (clkEn) begin
      downstreamBusNumber <= next_downstreamBusNumber;
    end
  end

endmodule : bch_header_regs
`default_nettype wire

// ===== bch_header_regs_assertions.sv
// Checker of the bridge header register block
`timescale 1ns/1ps
`default_nettype none
module bch_header_regs_chk (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        clkEn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [3:0]  pstrb,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        poisonedPacketReceived,
  input wire logic [7:0]  upstreamBusNumber
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  // Answers seen on the status, identity and header dwords
  wire logic rdSts = pready && !pwrite && paddr == bch_pkg::ADDR_CMD_STATUS;
  wire logic rdRev = pready && !pwrite && paddr == bch_pkg::ADDR_REV_CLASS;
  wire logic rdHdr = pready && !pwrite && paddr == bch_pkg::ADDR_CACHE_HDR;
  // Setup cycle, and an event followed by a status read
  sequence s_setup; psel && !penable && clkEn; endsequence
  sequence s_poison; poisonedPacketReceived && clkEn ##[1:2] s_setup ##0
    (!pwrite && paddr == bch_pkg::ADDR_CMD_STATUS); endsequence
  property p_ready; s_setup |=> pready; endproperty
  a_ready: assert property (p_ready) else $error("no answer after setup");
  property p_int; rdSts |-> !prdata[19]; endproperty
  a_int: assert property (p_int) else $error("interrupt status set");
  property p_cap; rdSts |-> prdata[20]; endproperty
  a_cap: assert property (p_cap) else $error("capability flag clear");
  property p_legacy; rdSts |-> (prdata & 32'h06A0_FFFF) == 0; endproperty
  a_legacy: assert property (p_legacy) else $error("legacy bits set");
  property p_class; rdRev |-> prdata[31:8] == 24'h060400; endproperty
  a_class: assert property (p_class) else $error("class code wrong");
  property p_hdr; rdHdr |-> prdata[31:8] == 24'h000100; endproperty
  a_hdr: assert property (p_hdr) else $error("header dword wrong");
  property p_bus; $changed(upstreamBusNumber) |-> $past(psel && penable && clkEn && pready
    && pwrite && pstrb[0] && paddr == bch_pkg::ADDR_BUS_NUM); endproperty
  a_bus: assert property (p_bus) else $error("bus number moved");
  property p_poison; s_poison |=> prdata[31]; endproperty
  a_poison: assert property (p_poison) else $error("poison flag missing");
  property p_unmap; pready && paddr == 8'h10 |-> pslverr && prdata == 0; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped answer wrong");
endmodule : bch_header_regs_chk
bind bch_header_regs bch_header_regs_chk u_chk (.*);
`default_nettype wire

// ===== tb_bch_header_regs.sv
// Self-checking bench of the bridge header register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h want %h", $time, a, e); end end
module tb_bch_header_regs;
  localparam logic [7:0] REV = 8'h3C; // Arbitrary revision code
  logic        clk_sys = 0, rst_b = 0, clkEn = 1, psel = 0, penable = 0, pwrite = 0;
  logic        pready, pslverr, er, parityErrorResponseEnable = 0, systemErrorReportEnable = 0;
  logic        parityErrorEvent = 0, completerAbortSent = 0, completerAbortReceived = 0;
  logic        unsupportedReqReceived = 0, errorMessageSent = 0, poisonedPacketReceived = 0;
  logic [7:0]  paddr = 0, upstreamBusNumber, downstreamBusNumber, ad [4] = '{4, 8, 12, 24};
  logic [31:0] pwdata = 0, prdata, rd, d, cl, bn, sts = 32'h0010_0000;
  logic [3:0]  pstrb = 0, s;
  int          errors = 0, compares = 0, seed = 32'hdd21aa44, i, j;
  always #2 clk_sys = ~clk_sys;
  bch_header_regs #(.SILICON_REV(REV)) uut (.*);
  // Byte-lane merge and the flag an event should raise
  function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] m);
    for (int k = 0; k < 4; k++) if (m[k]) o[8*k+:8] = n[8*k+:8];
    return o;
  endfunction : merge
  function automatic logic [31:0] flagOf(input int n, input logic pe, se);
    int pos [6] = '{24, 27, 28, 29, 30, 31};
    return ((n == 0 && !pe) || (n == 4 && !se)) ? 32'h0 : 32'h1 << pos[n];
  endfunction : flagOf
  // One APB transfer, held until ready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dd, input logic [3:0] ss);
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= dd;
    pstrb <= ss;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask : apb
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(0, a, 0, 0);
    `CHK(rd, e)
  endtask : rdc
  task final_report;
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  // Main sequence: unmapped read, random writes, events and clears
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1;
    rdc(8'h10, 32'h0);
    `CHK(er, 1'b1)
    cl = 32'h0001_0000;
    bn = 0;
    for (i = 0; i < 6; i++) begin
      d = i == 0 ? 32'hFFFF_FFFF : $random(seed);
      s = i == 0 ? 4'hF : 4'($random(seed));
      for (j = 0; j < 4; j++) apb(1, ad[j], d, s);
      cl = merge(cl, d, s & 4'h1);
      bn = merge(bn, d, s & 4'h3);
      rdc(ad[0], sts);
      rdc(ad[1], {24'h060400, REV});
      rdc(ad[2], cl);
      rdc(ad[3], bn);
      `CHK({downstreamBusNumber, upstreamBusNumber}, bn[15:0])
    end
    for (i = 0; i < 12; i++) begin
      {parityErrorResponseEnable, systemErrorReportEnable} <= 2'($random(seed));
      {poisonedPacketReceived, errorMessageSent, unsupportedReqReceived,
        completerAbortReceived, completerAbortSent, parityErrorEvent} <= 6'h1 << (i % 6);
      @(posedge clk_sys);
      {poisonedPacketReceived, errorMessageSent, unsupportedReqReceived,
        completerAbortReceived, completerAbortSent, parityErrorEvent} <= 6'h0;
      sts = sts | flagOf(i % 6, parityErrorResponseEnable, systemErrorReportEnable);
      rdc(ad[0], sts);
    end
    apb(1, ad[0], 32'hFFFF_FFFF, 4'h7);
    rdc(ad[0], sts);
    apb(1, ad[0], 32'hFFFF_FFFF, 4'h8);
    sts = sts & ~32'hC100_0000;
    rdc(ad[0], sts);
    `CHK(er, 1'b0)
    // An event while the clock enable is low is not recorded
    clkEn <= 0;
    poisonedPacketReceived <= 1;
    @(posedge clk_sys);
    clkEn <= 1;
    poisonedPacketReceived <= 0;
    rdc(ad[0], sts);
    // Clearing write while the event stands: the set wins
    poisonedPacketReceived <= 1;
    apb(1, ad[0], 32'h8000_0000, 4'h8);
    poisonedPacketReceived <= 0;
    rdc(ad[0], sts | 32'h8000_0000);
    final_report();
  end
  // Watchdog against a hung handshake
  initial begin
    #40000;
    errors++;
    final_report();
  end
endmodule : tb_bch_header_regs
`default_nettype wire
